// ===== pkg/rsc_map.svh
/*
  register offsets, field positions, reset values and timing counts for the
  reset and sleep controller. assumes a 100 MHz system clock.
*/
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// ----------------------------------------------------------------------------
// register map (bank selected by low nibble of the register pointer)
// ----------------------------------------------------------------------------
`define RSC_BANK_CFG        4'hF
`define RSC_OFF_PORT_CONFIG 4'h0
`define RSC_OFF_STOP_CFG    4'hB
`define RSC_OFF_WDOG_MODE   4'hF
`define RSC_OFF_PORT2_MODE  4'h6
`define RSC_OFF_PORT3_MODE  4'h7
`define RSC_OFF_STATUS      4'h1

// ----------------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------------
`define RSC_RST_PORT_CONFIG 8'h00
`define RSC_RST_STOP_CFG    8'h00
`define RSC_RST_WDOG_MODE   8'h00
`define RSC_RST_PORT2_MODE  8'h00
`define RSC_RST_PORT3_MODE  8'h00
`define RSC_STOP_BYPASS_BIT 5

// ----------------------------------------------------------------------------
// opcodes and restart address
// ----------------------------------------------------------------------------
`define RSC_OP_NOP          8'hFF
`define RSC_OP_STOP         8'h6F
`define RSC_OP_HALT         8'h7F
`define RSC_RESTART_ADDR    16'h000C

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RSC_CLK_HZ          100000000
`define RSC_RC_HZ           100000
`define RSC_RC_DIV          (`RSC_CLK_HZ / `RSC_RC_HZ)
`define RSC_DELAY_US        5000
`define RSC_DELAY_RC_CYC    ((`RSC_DELAY_US * (`RSC_RC_HZ / 1000)) / 1000)

`endif

// ===== pkg/rsc_pkg.sv
/*
  types for the reset and sleep controller.
  assumes rsc_map.svh is compiled alongside.
*/
package rsc_pkg;
  typedef enum logic [1:0] {RSC_RUN, RSC_HALT, RSC_STOP, RSC_DELAY} rsc_state_t;

  typedef struct packed {
    logic       cmp_out_p3;
    logic [1:0] open_drain_p01;
    logic [3:0] low_emi_p;
    logic       low_emi_osc;
  } rsc_port_cfg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsc_bus_req_t;
endpackage

// ===== core/rsc_rc_delay.sv
/*
  one-shot reset delay timer counting rc ticks divided down from the system clock.
  assumes rc_tick is a one-cycle enable from the rc divider.
*/
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_rc_delay
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  input  wire logic rc_tick,
  // status
  output logic      busy
);
  localparam int CNT_MAX = `RSC_DELAY_RC_CYC;

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        busy_r;
  logic        busy_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (start)
    begin
      cnt_nxt  = 16'h0000;
      busy_nxt = 1'b1;
    end
    else if (busy_r && rc_tick)
    begin
      if (cnt_r == 16'(CNT_MAX - 1))
        busy_nxt = 1'b0;
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
endmodule

// ===== core/rsc_top.sv
/*
  reset and sleep controller: reset delay timer, halt and stop states and the
  bank f configuration registers. assumes the core presents each executed
  opcode with a one-cycle strobe and reports interrupt acceptance.
*/
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_top
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // supply and reset sources (asynchronous pins)
  input  wire logic          power_good,
  input  wire logic          ext_reset,
  input  wire logic          stop_recover_src,
  // from the core and peripherals
  input  wire logic          watchdog_timeout,
  input  wire logic          op_valid,
  input  wire logic [7:0]    op_code,
  input  wire logic          irq_taken,
  // register bus
  input  wire logic [3:0]    register_pointer,
  input  wire rsc_bus_req_t  bus,
  output logic [7:0]         rdata,
  // to the core and clock tree
  output logic               core_reset,
  output logic               cpu_clk_en,
  output logic               periph_clk_en,
  output logic               xtal_en,
  output logic [15:0]        restart_addr,
  output logic               misuse,
  output rsc_port_cfg_t      port_config,
  output logic [7:0]         stop_config_reg,
  output logic [7:0]         watchdog_mode_reg,
  output logic [7:0]         port2_mode_reg,
  output logic [7:0]         port3_mode_reg
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       pg_d_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      // set high, but sync2_r resets low, so a supply already good still gives one pg_rise two cycles after reset release
      pg_d_r  <= 1'b1;
    end
    else
    begin
      sync1_r <= {power_good, ext_reset, stop_recover_src};
      sync2_r <= sync1_r;
      pg_d_r  <= sync2_r[2];
    end
  end

  logic pg_rise;
  logic ext_rst_s;
  logic recover_s;
  assign pg_rise   = sync2_r[2] && !pg_d_r;
  assign ext_rst_s = sync2_r[1];
  assign recover_s = sync2_r[0];

  // --------------------------------------------------------------------------
  // rc oscillator divider
  // --------------------------------------------------------------------------
  localparam int RC_DIV = `RSC_RC_DIV;
  logic [9:0] div_r;
  logic [9:0] div_nxt;
  logic       rc_tick;

  always_comb
  begin
    rc_tick = (div_r == 10'(RC_DIV - 1));
    div_nxt = rc_tick ? 10'h000 : div_r + 10'h001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      div_r <= 10'h000;
    else
      div_r <= div_nxt;
  end

  // --------------------------------------------------------------------------
  // sleep state machine
  // --------------------------------------------------------------------------
  rsc_state_t state_r;
  rsc_state_t state_nxt;
  logic       last_nop_r;
  logic       last_nop_nxt;
  logic       misuse_r;
  logic       misuse_nxt;
  logic       timer_start;
  logic       delay_busy;
  logic       stop_exit;
  logic       full_reset;

  function automatic logic is_sleep(input logic [7:0] op);
    is_sleep = (op == `RSC_OP_STOP) || (op == `RSC_OP_HALT);
  endfunction

  // power-up and external reset restart the delay and clear the bank f registers; stop recovery never clears them
  assign full_reset = pg_rise || ext_rst_s;
  assign stop_exit  = (state_r == RSC_STOP) && (recover_s || watchdog_timeout);

  always_comb
  begin
    state_nxt    = state_r;
    last_nop_nxt = last_nop_r;
    misuse_nxt   = misuse_r;
    timer_start  = 1'b0;
    if (op_valid)
      last_nop_nxt = (op_code == `RSC_OP_NOP);
    case (state_r)
      RSC_RUN:
      begin
        if (op_valid && is_sleep(op_code))
        begin
          // sleeping without a preceding no-op is flagged but still honoured
          misuse_nxt = !last_nop_r;
          if (op_code == `RSC_OP_STOP)
            state_nxt = RSC_STOP;
          else
            state_nxt = RSC_HALT;
        end
      end
      RSC_HALT:
      begin
        if (irq_taken)
          state_nxt = RSC_RUN;
      end
      RSC_STOP:
      begin
        if (stop_exit)
        begin
          if (!stop_config_reg[`RSC_STOP_BYPASS_BIT] || watchdog_timeout)
          begin
            timer_start = 1'b1;
            state_nxt   = RSC_DELAY;
          end
          else
            state_nxt = RSC_RUN;
        end
      end
      RSC_DELAY:
      begin
        if (!delay_busy)
          state_nxt = RSC_RUN;
      end
      default:
        state_nxt = RSC_RUN;
    endcase
    if (full_reset || (watchdog_timeout && state_r != RSC_STOP))
    begin
      timer_start = 1'b1;
      state_nxt   = RSC_DELAY;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r    <= RSC_DELAY;
      last_nop_r <= 1'b0;
      misuse_r   <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      last_nop_r <= last_nop_nxt;
      misuse_r   <= misuse_nxt;
    end
  end

  rsc_rc_delay u_delay
  (
    .clk     (clk),
    .rst     (rst),
    .start   (timer_start),
    .rc_tick (rc_tick),
    .busy    (delay_busy)
  );

  // --------------------------------------------------------------------------
  // clock and reset controls
  // --------------------------------------------------------------------------
  logic core_reset_r;
  logic cpu_en_r;
  logic periph_en_r;
  logic xtal_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_reset_r <= 1'b1;
      cpu_en_r     <= 1'b0;
      periph_en_r  <= 1'b0;
      xtal_r       <= 1'b1;
    end
    else
    begin
      core_reset_r <= (state_nxt == RSC_DELAY) || timer_start;
      cpu_en_r     <= (state_nxt == RSC_RUN);
      periph_en_r  <= (state_nxt == RSC_RUN) || (state_nxt == RSC_HALT);
      xtal_r       <= (state_nxt != RSC_STOP);
    end
  end

  assign core_reset    = core_reset_r;
  assign cpu_clk_en    = cpu_en_r;
  assign periph_clk_en = periph_en_r;
  assign xtal_en       = xtal_r;
  assign restart_addr  = `RSC_RESTART_ADDR;
  assign misuse        = misuse_r;

  // --------------------------------------------------------------------------
  // bank f configuration registers
  // --------------------------------------------------------------------------
  logic [7:0] pcfg_r;
  logic [7:0] pcfg_nxt;
  logic [7:0] scfg_r;
  logic [7:0] scfg_nxt;
  logic [7:0] wdm_r;
  logic [7:0] wdm_nxt;
  logic [7:0] p2m_r;
  logic [7:0] p2m_nxt;
  logic [7:0] p3m_r;
  logic [7:0] p3m_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       bank_hit;

  assign bank_hit = (register_pointer == `RSC_BANK_CFG);

  always_comb
  begin
    pcfg_nxt  = pcfg_r;
    scfg_nxt  = scfg_r;
    wdm_nxt   = wdm_r;
    p2m_nxt   = p2m_r;
    p3m_nxt   = p3m_r;
    rdata_nxt = 8'h00;
    if (bus.wr && bank_hit)
    begin
      if (bus.addr == `RSC_OFF_PORT_CONFIG)
        pcfg_nxt = bus.wdata;
      else if (bus.addr == `RSC_OFF_STOP_CFG)
        scfg_nxt = bus.wdata;
      else if (bus.addr == `RSC_OFF_WDOG_MODE)
        wdm_nxt = bus.wdata;
      else if (bus.addr == `RSC_OFF_PORT2_MODE)
        p2m_nxt = bus.wdata;
      else if (bus.addr == `RSC_OFF_PORT3_MODE)
        p3m_nxt = bus.wdata;
    end
    if (bus.rd && bank_hit)
    begin
      if (bus.addr == `RSC_OFF_PORT_CONFIG)
        rdata_nxt = pcfg_r;
      else if (bus.addr == `RSC_OFF_STOP_CFG)
        rdata_nxt = scfg_r;
      else if (bus.addr == `RSC_OFF_WDOG_MODE)
        rdata_nxt = wdm_r;
      else if (bus.addr == `RSC_OFF_PORT2_MODE)
        rdata_nxt = p2m_r;
      else if (bus.addr == `RSC_OFF_PORT3_MODE)
        rdata_nxt = p3m_r;
      else if (bus.addr == `RSC_OFF_STATUS)
        rdata_nxt = {5'h00, misuse_r, state_r};
    end
    // only supply-up and external reset clear the registers; stop recovery keeps them
    if (full_reset)
    begin
      pcfg_nxt = `RSC_RST_PORT_CONFIG;
      scfg_nxt = `RSC_RST_STOP_CFG;
      wdm_nxt  = `RSC_RST_WDOG_MODE;
      p2m_nxt  = `RSC_RST_PORT2_MODE;
      p3m_nxt  = `RSC_RST_PORT3_MODE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pcfg_r  <= `RSC_RST_PORT_CONFIG;
      scfg_r  <= `RSC_RST_STOP_CFG;
      wdm_r   <= `RSC_RST_WDOG_MODE;
      p2m_r   <= `RSC_RST_PORT2_MODE;
      p3m_r   <= `RSC_RST_PORT3_MODE;
      rdata_r <= 8'h00;
    end
    else
    begin
      pcfg_r  <= pcfg_nxt;
      scfg_r  <= scfg_nxt;
      wdm_r   <= wdm_nxt;
      p2m_r   <= p2m_nxt;
      p3m_r   <= p3m_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata             = rdata_r;
  assign port_config       = rsc_port_cfg_t'(pcfg_r);
  assign stop_config_reg   = scfg_r;
  assign watchdog_mode_reg = wdm_r;
  assign port2_mode_reg    = p2m_r;
  assign port3_mode_reg    = p3m_r;
endmodule

// ===== test/rsc_chk.sv
/* checker on the rsc_top ports.
   assumes the bench binds it to rsc_top */
`timescale 1ns/1ps
module rsc_chk
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic          clk,
  input wire logic          rst,
  // requests
  input wire logic          watchdog_timeout,
  input wire logic          op_valid,
  input wire logic [7:0]    op_code,
  input wire logic          irq_taken,
  input wire logic          stop_recover_src,
  input wire logic [3:0]    register_pointer,
  input wire rsc_bus_req_t  bus,
  // results
  input wire logic [7:0]    rdata,
  input wire logic          core_reset,
  input wire logic          cpu_clk_en,
  input wire logic          periph_clk_en,
  input wire logic          xtal_en,
  input wire logic [15:0]   restart_addr,
  input wire rsc_port_cfg_t port_config,
  input wire logic [7:0]    stop_config_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // rc phase is free running, so allow one tick below and two ticks above
  localparam int HOLD_MIN = 499000;
  localparam int HOLD_MAX = 502000;
  logic [19:0] hold_r;
  logic [19:0] hold_nxt;
  logic        run;
  logic        halt;
  logic        go;
  assign run  = cpu_clk_en && !core_reset;
  assign halt = !cpu_clk_en && xtal_en && !core_reset;
  assign go   = run && op_valid && !watchdog_timeout;
  always_comb hold_nxt = (rst || !core_reset) ? 20'h0_0000 : hold_r + 20'h0_0001;
  always_ff @(posedge clk) hold_r <= hold_nxt;

  halt_gate_a: assert property (go && op_code == 8'h7F |=> halt && periph_clk_en)
    else $error("halt entry wrong clocks");
  stop_off_a: assert property (go && op_code == 8'h6F |=> !cpu_clk_en && !xtal_en)
    else $error("stop entry left a clock on");
  halt_wake_a: assert property (halt && irq_taken && !watchdog_timeout |=> run)
    else $error("interrupt did not end halt");
  restart_a: assert property (restart_addr == 16'h000C)
    else $error("restart address wrong");
  wdog_start_a: assert property (watchdog_timeout |-> ##[1:3] core_reset)
    else $error("watchdog did not start delay");
  hold_len_a: assert property ($fell(core_reset) |-> hold_r >= HOLD_MIN)
    else $error("reset delay too short");
  hold_max_a: assert property (hold_r <= HOLD_MAX)
    else $error("reset delay too long");
  bypass_a: assert property (!xtal_en && stop_config_reg[5] && stop_recover_src
    |-> ##[1:5] run)
    else $error("bypassed recovery did not run");
  slow_rec_a: assert property (!xtal_en && !stop_config_reg[5] && stop_recover_src
    |-> ##[1:5] core_reset)
    else $error("recovery did not start delay");
  rd_cfg_a: assert property (bus.rd && register_pointer == 4'hF && bus.addr == 4'h0
    |=> rdata == $past(port_config))
    else $error("port config read wrong");
  bank_off_a: assert property (bus.rd && register_pointer != 4'hF |=> rdata == 8'h00)
    else $error("read outside bank f not zero");

  cover property (halt && irq_taken);
  cover property (!xtal_en && stop_recover_src);
  cover property ($fell(core_reset));
endmodule

// ===== test/rsc_core_model.sv
/* core stand-in issuing sleep opcodes and interrupt accepts.
   assumes one bench process calls its tasks */
`timescale 1ns/1ps
module rsc_core_model
(
  // clock
  input wire logic   clk,
  // to the controller
  output logic       op_valid,
  output logic [7:0] op_code,
  output logic       irq_taken
);
  initial
  begin
    op_valid = 1'b0;
    op_code = 8'h00;
    irq_taken = 1'b0;
  end
  // flush may be skipped only to provoke the misuse flag
  task automatic sleep(input logic [7:0] op, input bit flush);
    if (flush)
    begin
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= 8'hFF;
    end
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    @(posedge clk);
    op_valid <= 1'b0;
    op_code <= ~op;
  endtask
  task automatic take_irq();
    @(posedge clk);
    irq_taken <= 1'b1;
    @(posedge clk);
    irq_taken <= 1'b0;
  endtask
endmodule

// ===== test/rsc_top_bench.sv
/* bench for rsc_top driven through a core stand-in.
   assumes the fixed 5 ms delay, so two full delays set the run length */
`timescale 1ns/1ps
module rsc_top_bench;
  import rsc_pkg::*;
  logic          clk;
  logic          rst;
  logic          rec;
  logic          wdog;
  logic          pg;
  logic          xrst;
  logic [3:0]    rp;
  rsc_bus_req_t  bus;
  logic [7:0]    rdata;
  logic [7:0]    stop_cfg;
  logic [7:0]    p2_mode;
  logic [7:0]    wd_mode;
  logic [7:0]    p3_mode;
  logic          core_reset;
  logic          cpu_clk_en;
  logic          periph_clk_en;
  logic          xtal_en;
  logic          misuse;
  logic          op_valid;
  logic          irq_taken;
  logic [7:0]    op_code;
  logic [15:0]   restart_addr;
  rsc_port_cfg_t port_config;
  int            fail_count;
  int            total_checks;
  int            cyc;
  logic [7:0]    v;
  int            n;

  rsc_core_model u_rsc_core_model (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .irq_taken(irq_taken));
  rsc_top u_rsc_top (.clk(clk), .rst(rst), .power_good(pg), .ext_reset(xrst),
    .stop_recover_src(rec), .watchdog_timeout(wdog), .op_valid(op_valid),
    .op_code(op_code), .irq_taken(irq_taken), .register_pointer(rp), .bus(bus),
    .rdata(rdata), .core_reset(core_reset), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .xtal_en(xtal_en), .restart_addr(restart_addr),
    .misuse(misuse), .port_config(port_config), .stop_config_reg(stop_cfg),
    .watchdog_mode_reg(wd_mode), .port2_mode_reg(p2_mode), .port3_mode_reg(p3_mode));

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask
  // bounded wait for the core to run again; n counts the cycles spent
  task automatic wait_run(input int lim);
    n = 0;
    while (!(cpu_clk_en === 1'b1 && core_reset === 1'b0) && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wait_rst();
    n = 0;
    while (core_reset !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_regs();
    rd(4'h0);
    chk("cfg reset", v, 8'h00);
    wr(4'h0, 8'hA5);
    chk("cfg open drain", port_config.open_drain_p01, 2'b01);
    rd(4'h0);
    chk("cfg read", v, 8'hA5);
    @(posedge clk);
    rp <= 4'h3;
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk("other bank read", v, 8'h00);
    chk("other bank write", port_config, 8'hA5);
    @(posedge clk);
    rp <= 4'hF;
    rd(4'h9);
    chk("unmapped read", v, 8'h00);
  endtask
  task automatic t_delay();
    wait_run(600000);
    chk("delay length", n >= 499000 && n <= 502000, 1'b1);
    chk("restart", restart_addr, 16'h000C);
  endtask
  task automatic t_halt();
    u_rsc_core_model.sleep(8'h7F, 1'b1);
    settle();
    chk("halt cpu", cpu_clk_en, 1'b0);
    chk("halt xtal", xtal_en, 1'b1);
    chk("halt periph", periph_clk_en, 1'b1);
    chk("halt flush", misuse, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    chk("halt holds", cpu_clk_en, 1'b0);
    u_rsc_core_model.take_irq();
    wait_run(4);
    chk("halt wake", cpu_clk_en, 1'b1);
  endtask
  task automatic t_misuse();
    u_rsc_core_model.sleep(8'h7F, 1'b0);
    settle();
    chk("misuse", misuse, 1'b1);
    rd(4'h1);
    chk("status", v, {5'b0, 1'b1, RSC_HALT});
    u_rsc_core_model.take_irq();
    wait_run(4);
    chk("misuse wake", cpu_clk_en, 1'b1);
  endtask
  task automatic t_bypass();
    wr(4'hB, 8'h20);
    wr(4'h6, 8'h3C);
    wr(4'hF, 8'h5A);
    wr(4'h7, 8'h81);
    u_rsc_core_model.sleep(8'h6F, 1'b1);
    settle();
    chk("stop xtal", xtal_en, 1'b0);
    chk("stop periph", periph_clk_en, 1'b0);
    @(posedge clk);
    rec <= 1'b1;
    wait_run(10);
    rec <= 1'b0;
    chk("bypass run", core_reset, 1'b0);
    chk("keep stop cfg", stop_cfg, 8'h20);
    chk("keep port2", p2_mode, 8'h3C);
    chk("keep wdog mode", wd_mode, 8'h5A);
    chk("keep port3", p3_mode, 8'h81);
  endtask
  task automatic t_wdog();
    u_rsc_core_model.sleep(8'h6F, 1'b1);
    settle();
    @(posedge clk);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    wait_rst();
    chk("wdog ends stop", core_reset, 1'b1);
    wait_run(600000);
    chk("wdog delay", n >= 499000, 1'b1);
  endtask
  task automatic t_slow();
    wr(4'hB, 8'h00);
    u_rsc_core_model.sleep(8'h6F, 1'b1);
    settle();
    u_rsc_core_model.take_irq();
    settle();
    chk("irq in stop", xtal_en, 1'b0);
    @(posedge clk);
    rec <= 1'b1;
    wait_rst();
    chk("slow recovery", core_reset, 1'b1);
    chk("keep port2 slow", p2_mode, 8'h3C);
  endtask
  // supply rise and external reset both restart the delay and clear the registers
  task automatic t_resets();
    wr(4'hB, 8'h20);
    @(posedge clk);
    pg <= 1'b0;
    repeat (4) @(posedge clk);
    pg <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("power good clears", stop_cfg, 8'h00);
    chk("power good delay", core_reset, 1'b1);
    wr(4'h6, 8'h3C);
    @(posedge clk);
    xrst <= 1'b1;
    @(posedge clk);
    xrst <= 1'b0;
    settle();
    chk("ext reset clears", p2_mode, 8'h00);
    chk("ext reset delay", core_reset, 1'b1);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // two full delays plus the short scenarios
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1300000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    rst = 1'b1;
    rec = 1'b0;
    wdog = 1'b0;
    pg = 1'b1;
    xrst = 1'b0;
    rp = 4'hF;
    bus = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_delay();
    t_halt();
    t_misuse();
    t_bypass();
    t_wdog();
    t_slow();
    t_resets();
    stop_test();
  end
endmodule

bind rsc_top rsc_chk u_rsc_chk (.clk(clk), .rst(rst), .watchdog_timeout(watchdog_timeout),
  .op_valid(op_valid), .op_code(op_code), .irq_taken(irq_taken),
  .stop_recover_src(stop_recover_src), .register_pointer(register_pointer), .bus(bus),
  .rdata(rdata), .core_reset(core_reset), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .xtal_en(xtal_en), .restart_addr(restart_addr),
  .port_config(port_config), .stop_config_reg(stop_config_reg));
